// ===== pre_driver_map.vh
`ifndef PRE_DRIVER_MAP_VH
`define PRE_DRIVER_MAP_VH

// ==================================================
// clock and timing
`define CLK_HZ        50000000
`define US_CYC        (`CLK_HZ / 1000000)
`define RST_FILT_CYC  4'h8
`define RETRY_US      1000
// blank times in microseconds, index = 2-bit select
`define BLANK_00_US   10'h050
`define BLANK_01_US   10'h08c
`define BLANK_10_US   10'h118
`define BLANK_11_US   10'h230

// ==================================================
// serial frame layout
`define FRAME_BITS    5'h18
`define ADDR_MSB      23
`define ADDR_LSB      20
`define DATA_MSB      11
`define RD_LR_BIT     23
`define RD_FE_BIT     22

// ==================================================
// register addresses
`define ADDR_CTRL     4'h0
`define ADDR_CFG0     4'h1
`define ADDR_MASK     4'h7

// ==================================================
// fault configuration fields and reset values
`define CFG_W         12
`define CFG_STG_BIT   0
`define CFG_STB_LSB   1
`define CFG_TON_LSB   4
`define CFG_TOF_LSB   6
`define CFG_RT1_BIT   11
`define CFG_RST       12'h000
`define CTRL_RST      6'h00
`define MASK_RST      6'h00
// synchroniser idle: chip select high, all else low
`define SYNC_RST      28'h4000000

`endif

// ===== sync2.v
module sync2 #(
  parameter             WIDTH     = 1,
  parameter [WIDTH-1:0] RESET_VAL = {WIDTH{1'b0}}
) (
  // clock and reset
  input  wire             clk_in,
  input  wire             rst_in,
  // data
  input  wire [WIDTH-1:0] d_in,
  output reg  [WIDTH-1:0] q_out
);

  reg [WIDTH-1:0] meta_r;

  // ==================================================
  // two-stage synchroniser, meta_r feeds q_out only
  always @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      meta_r <= RESET_VAL;
      q_out  <= RESET_VAL;
    end
    else
    begin
      meta_r <= d_in;
      q_out  <= meta_r;
    end
  end

endmodule

// ===== gate_channel.v
`include "pre_driver_map.vh"

module gate_channel (
  // clock and reset
  input  wire       clk_in,
  input  wire       rst_in,
  // timing and control
  input  wire       tick_us_in,
  input  wire       run_in,
  input  wire       cmd_in,
  input  wire       gbit_fall_in,
  input  wire       mask_in,
  input  wire       retry_en_in,
  input  wire       retry_tick_in,
  input  wire       frame_done_in,
  input  wire [1:0] ton_sel_in,
  input  wire [1:0] tof_sel_in,
  // drain comparators
  input  wire       stb_cmp_in,
  input  wire       stg_cmp_in,
  input  wire       open_cmp_in,
  // outputs
  output reg        gate_out,
  output reg        bias_out,
  output reg  [2:0] faults_out
);

  reg  [9:0] blank_r;
  reg        stb_off_r;
  reg  [2:0] state_r;
  wire       det_en;
  wire       drive_nxt;
  wire       change;
  wire       settled;
  wire       stb_hit;
  wire       off_chk;

  function [9:0] blank_us;
    input [1:0] sel;
    begin
      case (sel)
        2'h0:    blank_us = `BLANK_00_US;
        2'h1:    blank_us = `BLANK_01_US;
        2'h2:    blank_us = `BLANK_10_US;
        default: blank_us = `BLANK_11_US;
      endcase
    end
  endfunction

  assign det_en    = run_in & ~mask_in;
  assign drive_nxt = run_in & cmd_in & ~stb_off_r;
  assign change    = drive_nxt ^ gate_out;
  assign settled   = (blank_r == 10'h000) & ~change;
  assign stb_hit   = det_en & gate_out & settled & stb_cmp_in;
  assign off_chk   = det_en & ~gate_out & settled;

  // ==================================================
  // gate, bias and blank timer
  always @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      gate_out <= 1'b0;
      bias_out <= 1'b0;
      blank_r  <= 10'h000;
    end
    else
    begin
      gate_out <= drive_nxt;
      bias_out <= det_en & ~drive_nxt;
      if (change)
        blank_r <= drive_nxt ? blank_us(ton_sel_in) : blank_us(tof_sel_in);
      else if (tick_us_in && blank_r != 10'h000)
        blank_r <= blank_r - 10'h001;
    end
  end

  // ==================================================
  // fault states and latched fault bits {open, stg, stb}
  always @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      stb_off_r  <= 1'b0;
      state_r    <= 3'h0;
      faults_out <= 3'h0;
    end
    else if (!run_in)
    begin
      stb_off_r  <= 1'b0;
      state_r    <= 3'h0;
      faults_out <= 3'h0;
    end
    else
    begin
      // set wins over every release path
      if (stb_hit)
        stb_off_r <= 1'b1;
      else if (gbit_fall_in || (retry_en_in && retry_tick_in))
        stb_off_r <= 1'b0;
      if (gate_out && settled && det_en)
        state_r[0] <= stb_cmp_in;
      if (off_chk)
        state_r[2:1] <= {open_cmp_in, stg_cmp_in};
      // latched bits drop only on a transfer after the state cleared
      faults_out <= state_r | (faults_out & ~{3{frame_done_in}});
    end
  end

endmodule

// ===== pre_driver_top.v
`include "pre_driver_map.vh"

module pre_driver_top #(
  parameter RETRY_US = `RETRY_US
) (
  // system
  input  wire        SYS_CLK_IN,
  input  wire        RST_IN,
  // serial link
  input  wire        CHIP_SELECT_LOW_IN,
  input  wire        SCK_IN,
  input  wire        SDI_IN,
  output wire        SDO_OUT,
  output wire        SDO_OE_OUT,
  // reset pin
  input  wire        RESET_LOW_IN,
  // channel inputs
  input  wire [5:0]  CHANNEL_DIRECT_INPUT_IN,
  input  wire [5:0]  STB_CMP_IN,
  input  wire [5:0]  STG_CMP_IN,
  input  wire [5:0]  OPEN_CMP_IN,
  // channel outputs
  output wire [5:0]  GATE_DRIVE_OUTPUT_OUT,
  output wire [5:0]  BIAS_ENABLE_OUT,
  output wire [5:0]  STG_THRESH_SEL_OUT,
  output wire [17:0] STB_THRESH_SEL_OUT,
  output wire        LOGIC_RESET_FLAG_OUT
);

  localparam integer    US_CYC_I   = `US_CYC;
  localparam integer    RETRY_I    = RETRY_US;
  localparam [5:0]      US_LAST    = US_CYC_I[5:0] - 6'h01;
  localparam [15:0]     RETRY_LAST = RETRY_I[15:0] - 16'h0001;

  // ==================================================
  // synchronised pins
  wire [27:0] sync_q;
  wire [5:0]  in_s;
  wire [5:0]  stb_s;
  wire [5:0]  stg_s;
  wire [5:0]  open_s;
  wire        sdi_s;
  wire        sck_s;
  wire        csn_s;
  wire        rstn_s;

  sync2 #(
    .WIDTH     (28),
    .RESET_VAL (`SYNC_RST)
  ) u_sync (
    .clk_in (SYS_CLK_IN),
    .rst_in (RST_IN),
    .d_in   ({RESET_LOW_IN, CHIP_SELECT_LOW_IN, SCK_IN, SDI_IN,
              OPEN_CMP_IN, STG_CMP_IN, STB_CMP_IN, CHANNEL_DIRECT_INPUT_IN}),
    .q_out  (sync_q)
  );

  assign in_s   = sync_q[5:0];
  assign stb_s  = sync_q[11:6];
  assign stg_s  = sync_q[17:12];
  assign open_s = sync_q[23:18];
  assign sdi_s  = sync_q[24];
  assign sck_s  = sync_q[25];
  assign csn_s  = sync_q[26];
  assign rstn_s = sync_q[27];

  // ==================================================
  // reset pin glitch filter
  reg  [3:0] rfilt_r;
  reg        reset_act_r;
  wire       run;

  // short low pulses on the pin are ignored
  always @(posedge SYS_CLK_IN or posedge RST_IN)
  begin
    if (RST_IN)
    begin
      rfilt_r     <= 4'h0;
      reset_act_r <= 1'b1;
    end
    else if (rstn_s)
    begin
      rfilt_r     <= 4'h0;
      reset_act_r <= 1'b0;
    end
    else if (rfilt_r >= `RST_FILT_CYC)
      reset_act_r <= 1'b1;
    else
      rfilt_r <= rfilt_r + 4'h1;
  end

  assign run = ~reset_act_r;

  // ==================================================
  // microsecond tick and shared retry timer
  reg  [5:0]  us_cnt_r;
  reg  [15:0] retry_cnt_r;
  wire        us_tick;
  wire        retry_tick;

  assign us_tick    = (us_cnt_r == US_LAST);
  assign retry_tick = us_tick & (retry_cnt_r == RETRY_LAST);

  always @(posedge SYS_CLK_IN or posedge RST_IN)
  begin
    if (RST_IN)
    begin
      us_cnt_r    <= 6'h00;
      retry_cnt_r <= 16'h0000;
    end
    else
    begin
      us_cnt_r <= us_tick ? 6'h00 : us_cnt_r + 6'h01;
      if (retry_tick)
        retry_cnt_r <= 16'h0000;
      else if (us_tick)
        retry_cnt_r <= retry_cnt_r + 16'h0001;
    end
  end

  // ==================================================
  // serial shifter
  reg         sck_q_r;
  reg         csn_q_r;
  reg  [23:0] shift_in_r;
  reg  [23:0] shift_out_r;
  reg  [4:0]  bits_r;
  reg         sdo_oe_r;
  reg         frame_done_r;
  wire        sck_rise;
  wire        sck_fall;
  wire        cs_fall;
  wire        cs_rise;
  wire        frame_ok;
  wire [3:0]  addr;
  wire [11:0] wdata;
  wire [17:0] faults;
  reg         lr_r;
  reg         frame_err_r;

  assign sck_rise = sck_s & ~sck_q_r;
  assign sck_fall = ~sck_s & sck_q_r;
  assign cs_fall  = csn_q_r & ~csn_s;
  assign cs_rise  = ~csn_q_r & csn_s;
  assign frame_ok = (bits_r == `FRAME_BITS);
  assign addr     = shift_in_r[`ADDR_MSB:`ADDR_LSB];
  assign wdata    = shift_in_r[`DATA_MSB:0];

  always @(posedge SYS_CLK_IN or posedge RST_IN)
  begin
    if (RST_IN)
    begin
      sck_q_r      <= 1'b0;
      csn_q_r      <= 1'b1;
      shift_in_r   <= 24'h000000;
      shift_out_r  <= 24'h000000;
      bits_r       <= 5'h00;
      sdo_oe_r     <= 1'b0;
      frame_done_r <= 1'b0;
    end
    else
    begin
      sck_q_r      <= sck_s;
      csn_q_r      <= csn_s;
      frame_done_r <= cs_rise;
      sdo_oe_r     <= ~csn_s;
      if (cs_fall)
      begin
        bits_r      <= 5'h00;
        // snapshot of status for this transfer
        shift_out_r <= {lr_r, frame_err_r, 4'h0, faults};
      end
      else if (!csn_s)
      begin
        if (sck_rise)
        begin
          shift_in_r <= {shift_in_r[22:0], sdi_s};
          if (bits_r != 5'h1f)
            bits_r <= bits_r + 5'h01;
        end
        // first bit already stands from the select edge
        if (sck_fall && bits_r != 5'h00)
          shift_out_r <= {shift_out_r[22:0], 1'b0};
      end
    end
  end

  assign SDO_OUT    = shift_out_r[23];
  assign SDO_OE_OUT = sdo_oe_r;

  // ==================================================
  // control, configuration and mask registers
  reg  [5:0]  gate_bits_r;
  reg  [71:0] cfg_r;
  reg  [5:0]  mask_r;
  reg  [5:0]  gfall_r;
  integer     i;

  always @(posedge SYS_CLK_IN or posedge RST_IN)
  begin
    if (RST_IN)
    begin
      gate_bits_r <= `CTRL_RST;
      cfg_r       <= {6{`CFG_RST}};
      mask_r      <= `MASK_RST;
      gfall_r     <= 6'h00;
      lr_r        <= 1'b1;
      frame_err_r <= 1'b0;
    end
    else if (reset_act_r)
    begin
      gate_bits_r <= `CTRL_RST;
      cfg_r       <= {6{`CFG_RST}};
      mask_r      <= `MASK_RST;
      gfall_r     <= 6'h00;
      lr_r        <= 1'b1;
      frame_err_r <= 1'b0;
    end
    else
    begin
      gfall_r <= 6'h00;
      if (frame_done_r)
        lr_r <= 1'b0;
      // short frame flagged, discarded; flag stands until a full frame carries it out
      if (cs_rise)
        frame_err_r <= ~frame_ok;
      if (cs_rise && frame_ok)
      begin
        case (addr)
          `ADDR_CTRL:
          begin
            gfall_r     <= gate_bits_r & ~wdata[5:0];
            gate_bits_r <= wdata[5:0];
          end
          `ADDR_MASK:
            mask_r <= wdata[5:0];
          default:
            gfall_r <= 6'h00;
        endcase
        for (i = 0; i < 6; i = i + 1)
          if (addr == `ADDR_CFG0 + i[3:0])
            cfg_r[i*`CFG_W +: `CFG_W] <= wdata;
      end
    end
  end

  assign LOGIC_RESET_FLAG_OUT = lr_r;

  // ==================================================
  // channels
  genvar c;
  generate
    for (c = 0; c < 6; c = c + 1)
    begin : ch
      assign STG_THRESH_SEL_OUT[c] = cfg_r[c*`CFG_W + `CFG_STG_BIT];
      assign STB_THRESH_SEL_OUT[3*c +: 3] = cfg_r[c*`CFG_W + `CFG_STB_LSB +: 3];

      gate_channel u_ch (
        .clk_in        (SYS_CLK_IN),
        .rst_in        (RST_IN),
        .tick_us_in    (us_tick),
        .run_in        (run),
        .cmd_in        (in_s[c] | gate_bits_r[c]),
        .gbit_fall_in  (gfall_r[c]),
        .mask_in       (mask_r[c]),
        .retry_en_in   (cfg_r[c*`CFG_W + `CFG_RT1_BIT]),
        .retry_tick_in (retry_tick),
        .frame_done_in (frame_done_r),
        .ton_sel_in    (cfg_r[c*`CFG_W + `CFG_TON_LSB +: 2]),
        .tof_sel_in    (cfg_r[c*`CFG_W + `CFG_TOF_LSB +: 2]),
        .stb_cmp_in    (stb_s[c]),
        .stg_cmp_in    (stg_s[c]),
        .open_cmp_in   (open_s[c]),
        .gate_out      (GATE_DRIVE_OUTPUT_OUT[c]),
        .bias_out      (BIAS_ENABLE_OUT[c]),
        .faults_out    (faults[3*c +: 3])
      );
    end
  endgenerate

endmodule

// ===== pd_checker.sv
module pd_checker (
  // system
  input logic        SYS_CLK_IN,
  input logic        RST_IN,
  // serial link
  input logic        CHIP_SELECT_LOW_IN,
  input logic        SCK_IN,
  input logic        SDO_OUT,
  input logic        SDO_OE_OUT,
  // channels
  input logic        RESET_LOW_IN,
  input logic [5:0]  GATE_DRIVE_OUTPUT_OUT,
  input logic [5:0]  BIAS_ENABLE_OUT,
  input logic [5:0]  STG_THRESH_SEL_OUT,
  input logic [17:0] STB_THRESH_SEL_OUT,
  input logic        LOGIC_RESET_FLAG_OUT
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge SYS_CLK_IN); endclocking
  default disable iff (RST_IN);
  // ==================================================
  // serial link
  property p_oe_idle;
    CHIP_SELECT_LOW_IN [*6] |-> !SDO_OE_OUT;
  endproperty
  a_oe_idle: assert property (p_oe_idle) else $error("output on while idle");
  property p_oe_on;
    $fell(CHIP_SELECT_LOW_IN) |-> ##[2:4] SDO_OE_OUT;
  endproperty
  a_oe_on: assert property (p_oe_on) else $error("output not enabled");
  // synchroniser delay puts the clock fall two samples back
  property p_sdo_edge;
    SDO_OE_OUT && $past(SDO_OE_OUT) && $changed(SDO_OUT) |-> !$past(SCK_IN, 2);
  endproperty
  a_sdo_edge: assert property (p_sdo_edge) else $error("data out moved off fall");
  property p_cfg_stable;
    !CHIP_SELECT_LOW_IN && !$past(CHIP_SELECT_LOW_IN, 4)
      |-> $stable(STB_THRESH_SEL_OUT) && $stable(STG_THRESH_SEL_OUT);
  endproperty
  a_cfg_stable: assert property (p_cfg_stable) else $error("setup moved in frame");
  // ==================================================
  // reset pin and channels
  property p_pin_gates;
    !RESET_LOW_IN && !$past(RESET_LOW_IN, 5) && !$past(RESET_LOW_IN, 10)
      && !$past(RESET_LOW_IN, 15) |-> GATE_DRIVE_OUTPUT_OUT == 6'h00;
  endproperty
  a_pin_gates: assert property (p_pin_gates) else $error("gate on in reset");
  property p_pin_cfg;
    !RESET_LOW_IN && !$past(RESET_LOW_IN, 5) && !$past(RESET_LOW_IN, 10)
      && !$past(RESET_LOW_IN, 15) |-> STB_THRESH_SEL_OUT == 18'h00000
      && STG_THRESH_SEL_OUT == 6'h00 && LOGIC_RESET_FLAG_OUT;
  endproperty
  a_pin_cfg: assert property (p_pin_cfg) else $error("setup kept in reset");
  property p_bias;
    (GATE_DRIVE_OUTPUT_OUT & BIAS_ENABLE_OUT) == 6'h00;
  endproperty
  a_bias: assert property (p_bias) else $error("bias with gate on");
  property p_lr_hold;
    (LOGIC_RESET_FLAG_OUT && CHIP_SELECT_LOW_IN) [*8] |=> LOGIC_RESET_FLAG_OUT;
  endproperty
  a_lr_hold: assert property (p_lr_hold) else $error("flag lost off frame");
  c_frame: cover property ($fell(CHIP_SELECT_LOW_IN));
  c_pin: cover property ($fell(RESET_LOW_IN));
  c_cfg: cover property ($changed(STB_THRESH_SEL_OUT));
endmodule

bind pre_driver_top pd_checker i_chk (
  .SYS_CLK_IN(SYS_CLK_IN), .RST_IN(RST_IN), .CHIP_SELECT_LOW_IN(CHIP_SELECT_LOW_IN),
  .SCK_IN(SCK_IN), .SDO_OUT(SDO_OUT), .SDO_OE_OUT(SDO_OE_OUT), .RESET_LOW_IN(RESET_LOW_IN),
  .GATE_DRIVE_OUTPUT_OUT(GATE_DRIVE_OUTPUT_OUT), .BIAS_ENABLE_OUT(BIAS_ENABLE_OUT),
  .STG_THRESH_SEL_OUT(STG_THRESH_SEL_OUT), .STB_THRESH_SEL_OUT(STB_THRESH_SEL_OUT),
  .LOGIC_RESET_FLAG_OUT(LOGIC_RESET_FLAG_OUT)
);

// ===== spi_host.sv
module spi_host (
  // clock
  input  logic clk_in,
  // serial link
  input  logic sdo_in,
  output logic cs_low_out,
  output logic sck_out,
  output logic sdi_out
);
  timeunit 1ns;
  timeprecision 1ps;
  initial
  begin
    cs_low_out = 1'b1;
    sck_out = 1'b0;
    sdi_out = 1'b0;
  end
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clk_in);
    #2;
  endtask
  // ==================================================
  // mode 0 frame; short frames send the top n bits
  task automatic xfer(input logic [23:0] tx, input int n, output logic [23:0] rx);
    rx = 24'h000000;
    wait_cyc(1);
    cs_low_out = 1'b0;
    for (int i = 0; i < n; i++)
    begin
      sdi_out = tx[23 - i];
      wait_cyc(4);
      sck_out = 1'b1;
      rx = {rx[22:0], sdo_in};
      wait_cyc(4);
      sck_out = 1'b0;
    end
    wait_cyc(4);
    cs_low_out = 1'b1;
    sdi_out = 1'b0;
    wait_cyc(8);
  endtask
endmodule

// ===== tb.sv
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk = 1'b0;
  logic        rst, pin_rst_low, cs_low, sck, sdi, sdo, sdo_oe, lr_flag;
  logic [5:0]  ch_in, stb_cmp, stg_cmp, open_cmp, gate, bias, stg_sel;
  logic [17:0] stb_sel;
  logic [23:0] rx;
  wire         sdo_pin;
  int          mismatches = 0;
  int          num_checks = 0;
  assign sdo_pin = sdo_oe ? sdo : 1'bz;
  always #10 clk = ~clk;
  pre_driver_top #(.RETRY_US(10)) i_dut (
    .SYS_CLK_IN(clk), .RST_IN(rst), .CHIP_SELECT_LOW_IN(cs_low), .SCK_IN(sck),
    .SDI_IN(sdi), .SDO_OUT(sdo), .SDO_OE_OUT(sdo_oe), .RESET_LOW_IN(pin_rst_low),
    .CHANNEL_DIRECT_INPUT_IN(ch_in), .STB_CMP_IN(stb_cmp), .STG_CMP_IN(stg_cmp),
    .OPEN_CMP_IN(open_cmp), .GATE_DRIVE_OUTPUT_OUT(gate), .BIAS_ENABLE_OUT(bias),
    .STG_THRESH_SEL_OUT(stg_sel), .STB_THRESH_SEL_OUT(stb_sel),
    .LOGIC_RESET_FLAG_OUT(lr_flag)
  );
  spi_host i_host (
    .clk_in(clk), .sdo_in(sdo_pin), .cs_low_out(cs_low), .sck_out(sck), .sdi_out(sdi)
  );
  // ==================================================
  // helpers
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask
  task automatic chk(input logic [23:0] got, input logic [23:0] exp, input string what);
    num_checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [11:0] d);
    i_host.xfer({a, 8'h00, d}, 24, rx);
  endtask
  task automatic finish_test;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // ==================================================
  // scenarios
  task automatic t_reset;
    ch_in = 6'h2a;
    cyc(8);
    chk(24'(gate), 24'h00002a, "gates");
    chk(24'(lr_flag), 24'h000001, "reset flag");
    chk(24'(sdo_oe), 24'h000000, "output enable");
    $display("test reset done");
  endtask
  task automatic t_ctrl;
    ch_in = 6'h00;
    i_host.xfer(24'h000015, 24, rx);
    chk(rx, 24'h800000, "first read");
    chk(24'(gate), 24'h000015, "serial gates");
    ch_in = 6'h2a;
    cyc(4);
    chk(24'(gate), 24'h00003f, "or of inputs");
    wr(4'h0, 12'h000);
    chk(24'(gate), 24'h00002a, "bits cleared");
    $display("test control done");
  endtask
  task automatic t_cfg;
    wr(4'h1, 12'h00b);
    wr(4'h6, 12'h00e);
    chk(24'(stg_sel), 24'h000001, "ground thresholds");
    chk(24'(stb_sel), 24'h038005, "battery thresholds");
    // a 20-bit frame must not reach the control register
    i_host.xfer(24'h00003f, 20, rx);
    chk(24'(gate), 24'h00002a, "short frame");
    i_host.xfer(24'h100000, 24, rx);
    chk(24'(rx[23:22]), 24'h000001, "frame error flag");
    $display("test config done");
  endtask
  task automatic t_fault;
    wr(4'h7, 12'h004);
    stb_cmp = 6'h06;
    open_cmp = 6'h08;
    stg_cmp = 6'h10;
    ch_in = 6'h06;
    // longest path is the 80 us blank after switch-off
    cyc(4300);
    chk(24'(gate), 24'h000004, "shut and masked");
    chk(24'(bias & 6'h18), 24'h000018, "off bias");
    i_host.xfer(24'h700004, 24, rx);
    chk(24'(rx[17:0]), 24'h002808, "fault bits");
    stb_cmp = 6'h00;
    open_cmp = 6'h00;
    stg_cmp = 6'h00;
    cyc(20);
    chk(24'(gate), 24'h000004, "shutdown held");
    $display("test fault done");
  endtask
  task automatic t_pin;
    pin_rst_low = 1'b0;
    cyc(25);
    chk(24'(gate), 24'h000000, "gates in reset");
    chk({stb_sel, stg_sel}, 24'h000000, "setup in reset");
    chk(24'(lr_flag), 24'h000001, "flag in reset");
    pin_rst_low = 1'b1;
    cyc(8);
    chk(24'(gate), 24'h000006, "shutdown cleared");
    i_host.xfer(24'h700000, 24, rx);
    chk(rx, 24'h800000, "faults cleared");
    $display("test reset pin done");
  endtask
  task automatic t_retry;
    // channel 1 has been on since the pin reset; retry mode on
    stb_cmp = 6'h02;
    wr(4'h2, 12'h800);
    cyc(4000);
    stb_cmp = 6'h00;
    // shared retry timer must have released the shutdown
    cyc(600);
    chk(24'(gate), 24'h000006, "retried gate");
    i_host.xfer(24'h700000, 24, rx);
    chk(rx, 24'h000008, "retry fault bit");
    $display("test retry done");
  endtask
  // ==================================================
  // main sequence and watchdog
  initial
  begin
    rst = 1'b1;
    pin_rst_low = 1'b1;
    ch_in = 6'h00;
    stb_cmp = 6'h00;
    stg_cmp = 6'h00;
    open_cmp = 6'h00;
    cyc(2);
    rst = 1'b0;
    cyc(2);
    t_reset();
    t_ctrl();
    t_cfg();
    t_fault();
    t_pin();
    t_retry();
    finish_test();
  end
  initial
  begin
    // the tests take about 224 us
    #600000;
    mismatches++;
    finish_test();
  end
endmodule
